//--- srdpb_defines.svh
// Purpose: register offsets, field positions, reset values for srdpb
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are local choices
`ifndef SRDPB_DEFINES_SVH
`define SRDPB_DEFINES_SVH

// register byte offsets
`define SRDPB_CTRL_OFS      12'h000
`define SRDPB_DIV_OFS       12'h004
`define SRDPB_FORCE_OFS     12'h008
`define SRDPB_STATUS_OFS    12'h00C

// control register fields
`define SRDPB_PD_BIT        0
`define SRDPB_BIAS_BIT      1
`define SRDPB_EVT_BIT       2

// reset values
`define SRDPB_PD_RST        1'h0
`define SRDPB_DIV_RST       7'h2F
`define SRDPB_BIAS_RST      1'h1
`define SRDPB_FORCE_RST     4'h0

`endif

//--- srdpb_pkg.sv
// Purpose: shared types for srdpb
// Assumes: nothing beyond the defines header
// Notes:   output state encoding for each sysref output
package srdpb_pkg;

  // rest state of one sysref output
  typedef enum logic [1:0] {
    SRDPB_OUT_RUN  = 2'b00, // toggling with divided clock
    SRDPB_OUT_LOW  = 2'b01, // static low rest
    SRDPB_OUT_XPT  = 2'b10, // cross-point bias rest
    SRDPB_OUT_OFF  = 2'b11  // powered down
  } srdpb_out_t;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } srdpb_apb_req_t;

endpackage

//--- srdpb_top.sv
// Purpose: sysref global power down, cascaded divider, output rest bias
// Assumes: single 250 MHz clock mclk, synchronous active-high rst
// Notes:   apb slave answers in the access cycle with no wait states
//          status word: ratio in bits 12:0, divided level in bit 13
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "srdpb_defines.svh"

module srdpb_top (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // apb slave
  input  wire srdpb_pkg::srdpb_apb_req_t apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // sysref outputs
  output logic [3:0]                  sysref_output,
  output srdpb_pkg::srdpb_out_t [3:0] sysref_out_state
);

  ////////////////////////////////////////////////////////////////////////////
  // stage ratio decode, each returns divide ratio
  // five bits, since the top code of a power-of-two stage is sixteen
  function automatic logic [4:0] stage_pow2(input logic [1:0] code);
    stage_pow2 = 5'h02 << code; // 00=2 01=4 10=8 11=16
  endfunction

  // product of the four serial stages; the largest is 4*16*16*5,
  // 5120, so thirteen bits carry every code without wrapping
  function automatic logic [12:0] total_ratio(input logic [6:0] d);
    logic [12:0] s1; // first stage, two or four
    logic [12:0] s2; // second stage, power of two
    logic [12:0] s3; // third stage, power of two
    logic [12:0] s4; // fourth stage, two to five
    s1 = d[6] ? 13'h0004 : 13'h0002;
    s2 = {8'h00, stage_pow2(d[5:4])};
    s3 = {8'h00, stage_pow2(d[3:2])};
    s4 = {11'h000, d[1:0]} + 13'h0002;
    total_ratio = 13'((s1 * s2) * (s3 * s4));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic              pd_r;        // global power down
  logic              bias_r;      // rest bias select
  logic              evt_r;       // sysref event in progress
  logic [6:0]        div_r;       // cascaded divider code
  logic [3:0]        force_r;     // per-output bias force
  logic [12:0]       cnt_r;       // divider half-period counter
  logic              phase_r;     // divided clock level
  logic              wr_en;       // apb write strobe
  logic              setup;       // apb setup cycle seen
  logic              hit;         // address maps to a register
  logic [12:0]       ratio;       // total division ratio
  logic [12:0]       half;        // half-period length
  logic              half_tick;   // one-cycle enable at half period end
  logic [31:0]       rd_mux;      // read data select

  // access phase write strobe; no wait states, so every access phase
  // is also the completing one and the write lands at its end
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;

  // setup cycle: the answer is prepared here so it stands in access
  assign setup = apb_req.psel & ~apb_req.penable;

  // total ratio of the current code, shared by divider and status
  assign ratio = total_ratio(div_r);

  // address decode; anything else is refused with an error answer
  always_comb begin
    unique case (apb_req.paddr)
      `SRDPB_CTRL_OFS, `SRDPB_DIV_OFS,
      `SRDPB_FORCE_OFS, `SRDPB_STATUS_OFS: hit = 1'b1;
      default:                             hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: power down, bias select, event
  always_ff @(posedge mclk) begin
    if (rst) begin
      pd_r   <= `SRDPB_PD_RST;
      bias_r <= `SRDPB_BIAS_RST;
      evt_r  <= 1'b0;
    end else if (wr_en && apb_req.paddr == `SRDPB_CTRL_OFS) begin
      pd_r   <= apb_req.pwdata[`SRDPB_PD_BIT];
      bias_r <= apb_req.pwdata[`SRDPB_BIAS_BIT];
      evt_r  <= apb_req.pwdata[`SRDPB_EVT_BIT];
    end
  end

  // divider code; every code is accepted and the choice among
  // settings with equal ratio is left to software
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_r <= `SRDPB_DIV_RST;
    end else if (wr_en && apb_req.paddr == `SRDPB_DIV_OFS) begin
      div_r <= apb_req.pwdata[6:0];
    end
  end

  // per-output bias force, one bit per output
  always_ff @(posedge mclk) begin
    if (rst) begin
      force_r <= `SRDPB_FORCE_RST;
    end else if (wr_en && apb_req.paddr == `SRDPB_FORCE_OFS) begin
      force_r <= apb_req.pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; status holds the ratio in bits 12:0, the level in bit 13
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (apb_req.paddr)
      `SRDPB_CTRL_OFS:   rd_mux = {29'h0000_0000, evt_r, bias_r, pd_r};
      `SRDPB_DIV_OFS:    rd_mux = {25'h000_0000, div_r};
      `SRDPB_FORCE_OFS:  rd_mux = {28'h000_0000, force_r};
      `SRDPB_STATUS_OFS: rd_mux = {18'h0_0000, phase_r, ratio};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer; each output comes straight from a flop
  // ready: one-cycle pulse in the access phase; registering it costs
  // no wait state because the answer is already known in setup
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // error: unmapped address, raised together with ready
  always_ff @(posedge mclk) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & ~hit;
    end
  end

  // read data: captured in setup, held until the next setup
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cascaded divider; the ratio is split into two half periods
  // odd totals cannot occur: first stage is always even
  assign half = ratio >> 1;

  // end of a half period; the slow rate exists only as this pulse,
  // every flop stays on mclk; >= keeps a shrunk code from stranding
  // the counter above its new end point
  assign half_tick = (cnt_r >= half - 13'h0001);

  // half-period counter
  always_ff @(posedge mclk) begin
    if (rst || pd_r) begin
      cnt_r <= 13'h0000; // defined restart point
    end else if (half_tick) begin
      cnt_r <= 13'h0000;
    end else begin
      cnt_r <= cnt_r + 13'h0001;
    end
  end

  // divided clock level, starts low after power up
  always_ff @(posedge mclk) begin
    if (rst || pd_r) begin
      phase_r <= 1'b0; // no edges while down
    end else if (half_tick) begin
      phase_r <= ~phase_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-output rest state
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        sysref_out_state[i] <= srdpb_pkg::SRDPB_OUT_OFF;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pd_r) begin
          sysref_out_state[i] <= srdpb_pkg::SRDPB_OUT_OFF;
        end else if (force_r[i] | evt_r) begin
          sysref_out_state[i] <= bias_r ? srdpb_pkg::SRDPB_OUT_XPT
                                        : srdpb_pkg::SRDPB_OUT_LOW;
        end else begin
          sysref_out_state[i] <= srdpb_pkg::SRDPB_OUT_RUN;
        end
      end
    end
  end

  // per-output level; resting or powered-down outputs are held low
  always_ff @(posedge mclk) begin
    if (rst) begin
      sysref_output <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pd_r | force_r[i] | evt_r) begin
          sysref_output[i] <= 1'b0;
        end else begin
          sysref_output[i] <= phase_r;
        end
      end
    end
  end

endmodule // srdpb_top

//--- srdpb_sva.sv
// Purpose: port checker for srdpb_top
// Assumes: zero wait apb answer, pready a one cycle pulse
// Notes:   low-phase hold check watches output zero, rest check output one
`timescale 1ns/1ps
module srdpb_sva (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire srdpb_pkg::srdpb_apb_req_t   apb_req,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [3:0]                  sysref_output,
  input wire srdpb_pkg::srdpb_out_t [3:0] sysref_out_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // answer comes only right after a setup cycle
  a_ready_access: assert property (pready |->
    $past(apb_req.psel && !apb_req.penable)) else $error("stray ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_zero: assert property (pslverr |->
    pready && (apb_req.pwrite || prdata == 32'h0000_0000))
    else $error("bad error answer");
  a_err_addr: assert property (pslverr |-> !($past(apb_req.paddr) inside
    {12'h000, 12'h004, 12'h008, 12'h00c})) else $error("mapped error");
  a_off_all: assert property (
    sysref_out_state[0] == srdpb_pkg::SRDPB_OUT_OFF |->
    sysref_out_state[3] == srdpb_pkg::SRDPB_OUT_OFF) else $error("part off");
  a_off_quiet: assert property (
    sysref_out_state[0] == srdpb_pkg::SRDPB_OUT_OFF |->
    sysref_output == 4'h0) else $error("edges while off");
  a_rest_quiet: assert property (
    sysref_out_state[1] inside {srdpb_pkg::SRDPB_OUT_LOW,
    srdpb_pkg::SRDPB_OUT_XPT} |-> !sysref_output[1]) else $error("rest moves");
  // shortest total ratio is 16, so a low phase lasts at least 8 cycles
  a_low_hold: assert property (
    $fell(sysref_output[0]) |=> (!sysref_output[0] ||
    sysref_out_state[0] != srdpb_pkg::SRDPB_OUT_RUN)[*7])
    else $error("low phase short");
endmodule // srdpb_sva
bind srdpb_top srdpb_sva srdpb_sva_inst (.mclk(mclk), .rst(rst),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sysref_output(sysref_output), .sysref_out_state(sysref_out_state));

//--- srdpb_top_bench.sv
// Purpose: self-checking bench for srdpb_top
// Assumes: zero wait apb answer, offsets from the defines header
// Notes:   divider codes change only while powered down, avoiding glitches
`timescale 1ns/1ps
`include "srdpb_defines.svh"
module srdpb_top_bench;
  logic                        mclk = 1'b0;
  logic                        rst  = 1'b1;
  srdpb_pkg::srdpb_apb_req_t   req  = '0;
  logic [31:0]                 prdata, rd;
  logic                        pready, pslverr, er;
  logic [3:0]                  out;
  srdpb_pkg::srdpb_out_t [3:0] st;
  int                          miscompares = 0, compares = 0;
  always #2 mclk = ~mclk; // 250 MHz
  srdpb_top srdpb_top_inst (.mclk(mclk), .rst(rst), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysref_output(out), .sysref_out_state(st));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // one apb transfer, then idle cycles so outputs settle
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    rd = prdata;
    er = pslverr;
    req <= '0;
    repeat (3) @(posedge mclk);
    if (n >= 9) begin
      miscompares++;
      complete_run;
    end
  endtask
  // count edges until out[0] leaves lvl; a stuck output ends the run
  task automatic wait_out(input logic lvl, output int n);
    n = 0;
    while (out[0] === lvl && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40) begin
      miscompares++;
      complete_run;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, `SRDPB_CTRL_OFS, '0);
    chk(rd === 32'h0000_0002, "ctrl reset");
    apb(1'b0, `SRDPB_STATUS_OFS, '0);
    chk(rd[12:0] === 13'h0500, "reset ratio");
  endtask
  task automatic t_ratio;
    logic [6:0] c [6] = '{7'h05, 7'h2e, 7'h0b, 7'h1e, 7'h7f, 7'h00};
    int         e [6] = '{48, 1024, 160, 512, 5120, 16};
    int         n;
    apb(1'b1, `SRDPB_CTRL_OFS, 32'h0000_0001);
    chk(st[0] === srdpb_pkg::SRDPB_OUT_OFF, "not off");
    chk(out === 4'h0, "level while off");
    foreach (c[i]) begin
      apb(1'b1, `SRDPB_DIV_OFS, {25'h0, c[i]});
      apb(1'b0, `SRDPB_STATUS_OFS, '0);
      chk(rd[12:0] === 13'(e[i]), "ratio");
    end
    apb(1'b1, `SRDPB_CTRL_OFS, '0);
    wait_out(1'b0, n);
    wait_out(1'b1, n);
    chk(n == 8, "half period");
  endtask
  task automatic t_bias;
    apb(1'b1, `SRDPB_FORCE_OFS, 32'h0000_0001);
    chk(st[0] === srdpb_pkg::SRDPB_OUT_LOW, "forced");
    chk(st[1] === srdpb_pkg::SRDPB_OUT_RUN, "unforced");
    apb(1'b1, `SRDPB_CTRL_OFS, 32'h0000_0006);
    chk(st[2] === srdpb_pkg::SRDPB_OUT_XPT, "event xpt");
    apb(1'b1, 12'h010, 32'h0000_0004);
    chk(er === 1'b1, "unmapped");
    apb(1'b0, `SRDPB_CTRL_OFS, '0);
    chk(rd === 32'h0000_0006, "ctrl kept");
    apb(1'b1, `SRDPB_CTRL_OFS, 32'h0000_0004);
    chk(st[2] === srdpb_pkg::SRDPB_OUT_LOW, "event low");
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_ratio;
    t_bias;
    complete_run;
  end
endmodule // srdpb_top_bench
